/* src/eac_pkg.sv */
// eeprom access controller: shared constants, register map and types
// assumes a 25 MHz bus clock and a two-wire serial eeprom on the far side
package eac_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets on the bus
   localparam logic [7:0] OFF_CTRL = 8'hdc;
   localparam logic [7:0] OFF_IRQ_STS = 8'he0;
   localparam logic [7:0] OFF_IRQ_MASK = 8'he4;

   // control dword field positions
   localparam int CB_START = 0;
   localparam int CB_CMD = 1;
   localparam int CB_ERR = 2;
   localparam int CB_AL_OK = 3;
   localparam int CB_AL_STS = 4;
   localparam int CB_AL_DIS = 5;
   localparam int CB_RATE = 6;
   localparam int CB_ADDR = 9;
   localparam int CB_DATA = 16;

   // values after reset
   localparam logic CMD_RST = 1'b0;
   localparam logic AL_DIS_RST = 1'b1;
   localparam logic [1:0] RATE_RST = 2'b01;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [15:0] DATA_RST = 16'h0000;

   // clock rate codes
   localparam logic [1:0] RATE_DIV = 2'b01;
   localparam logic [1:0] RATE_TEST = 2'b11;

   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_NACK = 1;
   localparam int IRQ_AL = 2;
   localparam int IRQ_W = 3;

   ////////////////////////////////////////////////////////////////////////
   // timing: eeprom clock is the 125 MHz primary clock divided by 1024
   localparam int PRI_CLK_PS = 8000;
   localparam int EE_DIV = 1024;
   localparam int HCLK_PS = 40000;
   // one quarter of an eeprom clock period, rounded up so never too fast
   localparam int QTR_CYC = (PRI_CLK_PS * EE_DIV + 4 * HCLK_PS - 1)
                            / (4 * HCLK_PS);
   localparam logic [5:0] QTR_LIMIT = 6'(QTR_CYC);
   localparam logic [5:0] TEST_LIMIT = 6'h01;

   // serial framing
   localparam logic [7:0] DEV_WR = 8'ha0;
   localparam logic [7:0] DEV_RD = 8'ha1;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [2:0] WR_LAST = 3'h5;
   localparam logic [2:0] RD_LAST = 3'h7;

   // automatic load: words read from the eeprom base address
   localparam logic [6:0] AL_BASE = 7'h00;
   localparam logic [1:0] AL_LAST = 2'h3;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_TX = 3'b010,
      ST_RX = 3'b011,
      ST_STOP = 3'b100
   } eac_state_e;

endpackage

/* src/eac_top.sv */
// eeprom access controller: control register, serial engine, autoload
// assumes a single ahb-lite master, synchronous pins and an external
// pull-up on the data wire
//
// Overview of operation
// - writing start to one launches one eeprom cycle; start resets to zero.
// - the command bit picks read (0) or write (1) and resets to zero.
// - a missing acknowledge during a cycle sets the read-only error flag.
// - autoload success bit 3 shows a good load and clears when read.
// - autoload status shows a good load after the reset pin, not read-clear.
// - a good automatic load writes the eeprom words into configuration.
// - autoload disable, reset to one, suppresses the automatic load.
// - clock rate bits 7:6, reset 01b, divide 125 MHz by 1024, 11b is test.
// - the control dword sits only at offset dch.
// - bits 31:16 hold write data and receive the word of a read.
`timescale 1ns/100ps
`default_nettype none

module eac_top
   import eac_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // device reset pin, high while held in reset
   input wire logic fundamental_reset_in,
   // serial eeprom pins
   output logic ee_scl,
   input wire logic ee_sda_in,
   output logic ee_sda_out,
   output logic ee_sda_oe,
   // configuration load port
   output logic cfg_wr_valid,
   output logic [1:0] cfg_wr_index,
   output logic [15:0] cfg_wr_data,
   // interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // access kind of each step of a cycle
   function automatic eac_state_e step_kind(input logic wr,
                                            input logic [2:0] s);
      eac_state_e k;
      k = ST_STOP;
      if (wr)
      begin
         case (s)
            3'h0: k = ST_START;
            3'h1, 3'h2, 3'h3, 3'h4: k = ST_TX;
            default: k = ST_STOP;
         endcase
      end
      else
      begin
         case (s)
            3'h0, 3'h3: k = ST_START;
            3'h1, 3'h2, 3'h4: k = ST_TX;
            3'h5, 3'h6: k = ST_RX;
            default: k = ST_STOP;
         endcase
      end
      return k;
   endfunction

   // byte sent at a transmit step
   function automatic logic [7:0] tx_byte(input logic wr,
                                          input logic [2:0] s,
                                          input logic [6:0] a,
                                          input logic [15:0] d);
      logic [7:0] b;
      b = 8'hff;
      case (s)
         3'h1: b = DEV_WR;
         3'h2: b = {1'b0, a};
         3'h3: b = wr ? d[15:8] : 8'hff;
         3'h4: b = wr ? d[7:0] : DEV_RD;
         default: b = 8'hff;
      endcase
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state
   logic ctrl_start, ctrl_cmd, ctrl_err, al_ok, al_sts, ctrl_al_dis;
   logic [1:0] ctrl_rate;
   logic [6:0] ctrl_addr;
   logic [15:0] ctrl_data;
   logic [IRQ_W-1:0] irq_sts, irq_mask;
   logic dp_wr, dp_rd, rd_done;
   logic [7:0] dp_addr;
   eac_state_e state, next_state;
   logic [1:0] q, next_q;
   logic [3:0] bitc, next_bitc;
   logic [2:0] step, next_step;
   logic [7:0] shreg, next_sh;
   logic [15:0] rxw, next_rx;
   logic scl, next_scl, sda, next_sda;
   logic nack_seen, next_nack, op_write, next_opw;
   logic [5:0] div_cnt;
   logic al_active;
   logic [1:0] al_idx;
   logic prst_q;

   ////////////////////////////////////////////////////////////////////////
   // bus decode; only whole-word transfers are taken
   wire ap = hsel & hready & htrans[1] & (hsize == 3'b010);
   wire wr_ev = dp_wr;
   wire rd_cap = dp_rd & ~rd_done;
   wire sel_ctrl = (dp_addr == OFF_CTRL);
   wire sel_sts = (dp_addr == OFF_IRQ_STS);
   wire sel_mask = (dp_addr == OFF_IRQ_MASK);
   wire busy = (state != ST_IDLE);
   wire idle_all = ~busy & ~al_active;
   wire wr_ctrl = wr_ev & sel_ctrl;

   // launch sources; autoload wins over a start in the same cycle
   wire prst_fall = prst_q & ~fundamental_reset_in;
   wire go_al = prst_fall & ~ctrl_al_dis & idle_all;
   wire go_sw = wr_ctrl & hwdata[CB_START] & idle_all & ~go_al;
   wire tick = busy & (div_cnt == ((ctrl_rate == RATE_TEST) ?
                                   TEST_LIMIT : QTR_LIMIT) - 6'h01);
   wire fin = tick & (state == ST_STOP) & (q == 2'h3);
   wire al_next = fin & al_active & ~nack_seen & (al_idx != AL_LAST);
   wire launch = go_sw | go_al | al_next;
   wire launch_wr = go_sw & hwdata[CB_CMD];
   wire nack_evt = tick & (state == ST_TX) & (q == 2'h2) &
                   (bitc == ACK_SLOT) & ee_sda_in;
   wire al_good = fin & al_active & ~nack_seen & (al_idx == AL_LAST);
   wire al_end = fin & al_active & (nack_seen | (al_idx == AL_LAST));
   wire sw_done = fin & ~al_active;
   wire rd_clr_ok = rd_cap & sel_ctrl;
   wire [6:0] al_addr = AL_BASE + 7'(al_idx);
   wire [6:0] cur_addr = al_active ? al_addr : ctrl_addr;
   wire [2:0] step_n = step + 3'h1;
   wire [IRQ_W-1:0] irq_set = {al_end, nack_evt, sw_done};

   // readback words; unmapped offsets read zero
   wire [31:0] ctrl_word = {ctrl_data, ctrl_addr, 1'b0, ctrl_rate,
                            ctrl_al_dis, al_sts, al_ok, ctrl_err,
                            ctrl_cmd, ctrl_start};
   wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                         sel_sts ? {29'h0, irq_sts} :
                         sel_mask ? {29'h0, irq_mask} : 32'h0;

   // reads take one wait state so hrdata comes from a flop
   assign hreadyout = ~rd_cap;
   assign hresp = 1'b0;
   assign irq = |(irq_sts & irq_mask);
   assign ee_scl = scl;
   assign ee_sda_out = 1'b0;
   assign ee_sda_oe = ~sda; // open drain: drive only the low level

   ////////////////////////////////////////////////////////////////////////
   // ahb address and data phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         rd_done <= 1'b0;
         dp_addr <= 8'h00;
      end
      else if (ap)
      begin
         dp_wr <= hwrite;
         dp_rd <= ~hwrite;
         rd_done <= 1'b0;
         dp_addr <= haddr[7:0];
      end
      else if (hready)
      begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         rd_done <= 1'b0;
      end
      else if (dp_rd)
      begin
         rd_done <= 1'b1;
      end
   end

   // read data capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (rd_cap)
         hrdata <= rd_word;
   end

   ////////////////////////////////////////////////////////////////////////
   // software fields; changes are ignored while a cycle is running
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_cmd <= CMD_RST;
         ctrl_al_dis <= AL_DIS_RST;
         ctrl_rate <= RATE_RST;
         ctrl_addr <= ADDR_RST;
      end
      else if (wr_ctrl & idle_all)
      begin
         ctrl_cmd <= hwdata[CB_CMD];
         ctrl_al_dis <= hwdata[CB_AL_DIS];
         ctrl_rate <= hwdata[CB_RATE+1:CB_RATE];
         ctrl_addr <= hwdata[CB_ADDR+6:CB_ADDR];
      end
   end

   // data field: software word, replaced by the word a read returns
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_data <= DATA_RST;
      else if (sw_done & ~op_write & ~nack_seen)
         ctrl_data <= rxw;
      else if (wr_ctrl & idle_all)
         ctrl_data <= hwdata[CB_DATA+15:CB_DATA];
   end

   // start bit stays set for the whole cycle, then clears for polling
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_start <= 1'b0;
      else if (go_sw)
         ctrl_start <= 1'b1;
      else if (sw_done)
         ctrl_start <= 1'b0;
   end

   // error flag: a new start clears it, a missing ack sets it (set wins)
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_err <= 1'b0;
      else if (nack_evt)
         ctrl_err <= 1'b1;
      else if (go_sw)
         ctrl_err <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // autoload flags; success clears on read unless set in that cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         al_ok <= 1'b0;
         al_sts <= 1'b0;
      end
      else if (al_good)
      begin
         al_ok <= 1'b1;
         al_sts <= 1'b1;
      end
      else if (go_al | al_end)
      begin
         al_ok <= 1'b0;
         al_sts <= 1'b0;
      end
      else if (rd_clr_ok)
      begin
         al_ok <= 1'b0;
      end
   end

   // autoload word sequencing and the reset pin edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         al_active <= 1'b0;
         al_idx <= 2'h0;
         prst_q <= 1'b0;
      end
      else
      begin
         prst_q <= fundamental_reset_in;
         if (go_al)
         begin
            al_active <= 1'b1;
            al_idx <= 2'h0;
         end
         else if (al_next)
            al_idx <= al_idx + 2'h1;
         else if (al_end)
            al_active <= 1'b0;
      end
   end

   // each good word goes out to configuration as a one-cycle write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_wr_valid <= 1'b0;
         cfg_wr_index <= 2'h0;
         cfg_wr_data <= 16'h0;
      end
      else
      begin
         cfg_wr_valid <= fin & al_active & ~nack_seen;
         if (fin & al_active & ~nack_seen)
         begin
            cfg_wr_index <= al_idx;
            cfg_wr_data <= rxw;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear; a new event wins the clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_sts <= '0;
         irq_mask <= '0;
      end
      else
      begin
         irq_sts <= (irq_sts & ~((wr_ev & sel_sts) ? hwdata[IRQ_W-1:0] :
                                 {IRQ_W{1'b0}})) | irq_set;
         if (wr_ev & sel_mask)
            irq_mask <= hwdata[IRQ_W-1:0];
      end
   end

   // quarter-bit divider, runs only during a cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_cnt <= 6'h00;
      else if (~busy | tick)
         div_cnt <= 6'h00;
      else
         div_cnt <= div_cnt + 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // serial engine: four quarters per bit, scl high in quarters 2 and 3
   always_comb
   begin
      logic adv;
      adv = 1'b0;
      next_state = state;
      next_q = q;
      next_bitc = bitc;
      next_step = step;
      next_sh = shreg;
      next_rx = rxw;
      next_scl = scl;
      next_sda = sda;
      next_nack = nack_seen;
      next_opw = op_write;
      if (launch)
      begin
         next_state = ST_START;
         next_q = 2'h0;
         next_step = 3'h0;
         next_nack = 1'b0;
         next_opw = launch_wr;
      end
      else if (tick)
      begin
         next_q = q + 2'h1;
         case (state)
            ST_START:
            begin
               case (q)
                  2'h0: begin next_scl = 1'b0; next_sda = 1'b1; end
                  2'h1: next_scl = 1'b1;
                  2'h2: next_sda = 1'b0;
                  default: begin next_scl = 1'b0; adv = 1'b1; end
               endcase
            end
            ST_TX:
            begin
               case (q)
                  2'h0:
                  begin
                     next_scl = 1'b0;
                     next_sda = (bitc == ACK_SLOT) ? 1'b1 : shreg[7];
                  end
                  2'h1: next_scl = 1'b1;
                  2'h2:
                     if (bitc == ACK_SLOT)
                        next_nack = ee_sda_in;
                  default:
                  begin
                     next_scl = 1'b0;
                     if (bitc != ACK_SLOT)
                     begin
                        next_sh = {shreg[6:0], 1'b1};
                        next_bitc = bitc + 4'h1;
                     end
                     else if (nack_seen)
                        next_state = ST_STOP;
                     else
                        adv = 1'b1;
                  end
               endcase
            end
            ST_RX:
            begin
               case (q)
                  2'h0:
                  begin
                     next_scl = 1'b0;
                     // ack the high byte, not the last one
                     next_sda = (bitc == ACK_SLOT) ? (step == 3'h6) : 1'b1;
                  end
                  2'h1: next_scl = 1'b1;
                  2'h2:
                     if (bitc != ACK_SLOT)
                        next_rx = {rxw[14:0], ee_sda_in};
                  default:
                  begin
                     next_scl = 1'b0;
                     if (bitc == ACK_SLOT)
                        adv = 1'b1;
                     else
                        next_bitc = bitc + 4'h1;
                  end
               endcase
            end
            ST_STOP:
            begin
               case (q)
                  2'h0: begin next_scl = 1'b0; next_sda = 1'b0; end
                  2'h1: next_scl = 1'b1;
                  2'h2: next_sda = 1'b1;
                  default: next_state = ST_IDLE;
               endcase
            end
            default: next_state = ST_IDLE;
         endcase
         if (adv)
         begin
            next_step = step_n;
            next_state = step_kind(op_write, step_n);
            next_bitc = 4'h0;
            next_sh = tx_byte(op_write, step_n, cur_addr, ctrl_data);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ST_IDLE;
         q <= 2'h0;
         bitc <= 4'h0;
         step <= 3'h0;
         shreg <= 8'hff;
         rxw <= 16'h0;
         scl <= 1'b1;
         sda <= 1'b1;
         nack_seen <= 1'b0;
         op_write <= 1'b0;
      end
      else
      begin
         state <= next_state;
         q <= next_q;
         bitc <= next_bitc;
         step <= next_step;
         shreg <= next_sh;
         rxw <= next_rx;
         scl <= next_scl;
         sda <= next_sda;
         nack_seen <= next_nack;
         op_write <= next_opw;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_start_begins_cycle: assert property (
      go_sw |=> state == ST_START && ctrl_start)
      else $error("start did not launch a cycle");
   a_cmd_picks_type: assert property (
      go_sw |=> op_write == $past(hwdata[CB_CMD]))
      else $error("wrong access type");
   a_nack_sets_error: assert property (
      nack_evt |=> ctrl_err [*2])
      else $error("missing ack not flagged");
   a_success_read_clear: assert property (
      rd_clr_ok && !al_good |=> !al_ok)
      else $error("success flag survived a read");
   a_status_holds_read: assert property (
      al_sts && rd_clr_ok && !go_al |=> al_sts)
      else $error("status flag cleared by read");
   a_cfg_load_data: assert property (
      al_good |=> cfg_wr_valid && cfg_wr_index == AL_LAST)
      else $error("last word not loaded");
   a_disable_blocks_load: assert property (
      prst_fall && ctrl_al_dis |=> !al_active)
      else $error("autoload ran while disabled");
   a_quarter_spacing: assert property (
      tick && ctrl_rate != RATE_TEST |=> !tick [*8])
      else $error("eeprom clock too fast");
   a_unmapped_zero: assert property (
      rd_cap && !sel_ctrl && !sel_sts && !sel_mask |=> hrdata == 32'h0)
      else $error("unmapped read");
   a_read_word_stored: assert property (
      sw_done && !op_write && !nack_seen |=> ctrl_data == $past(rxw))
      else $error("read word lost");
   a_done_clears_start: assert property (
      sw_done |=> !ctrl_start && state == ST_IDLE)
      else $error("start not cleared");

   c_write_cycle: cover property (sw_done && op_write && !nack_seen);
   c_read_cycle: cover property (sw_done && !op_write && !nack_seen);
   c_autoload_ok: cover property (al_good);
   c_nack_abort: cover property (nack_evt ##[1:300] sw_done);

endmodule

`default_nettype wire

/* tb/eac_ee_model.sv */
// serial eeprom model: 128 words, acks every byte it receives unless told not to
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none
module eac_ee_model
(
   // serial wires
   input wire logic scl,
   input wire logic sda,
   // fault request and data pull-down
   input wire logic nak,
   output logic pull
);
   logic [15:0] mem [128];
   logic [7:0] sh;
   logic [6:0] a;
   logic rd;
   int n;
   int ph;
   initial pull = 1'b0;
   // start condition: data falls while the clock is high
   always @(negedge sda)
      if (scl)
      begin
         n = -1;
         ph = 0;
      end
   // shift bits in while the clock is high
   always @(posedge scl)
      if (n < 8)
         sh = {sh[6:0], sda};
   // ack and read data change only while the clock is low
   always @(negedge scl)
   begin
      n = n + 1;
      pull = 1'b0; // released wire floats up, never holds stale data
      if (n == 9)
      begin
         n = 0;
         ph = ph + 1;
      end
      if (n == 8 && (ph == 0 || !rd))
      begin
         pull = !nak;
         if (ph == 0) rd = sh[0];
         if (ph == 1) a = sh[6:0];
         if (ph == 2) mem[a][15:8] = sh;
         if (ph == 3) mem[a][7:0] = sh;
      end
      else if (rd && (ph == 1 || ph == 2) && n < 8)
         pull = !mem[a][(ph == 1 ? 15 : 7) - n];
   end
endmodule
`default_nettype wire

/* tb/test_eeprom_access_controller.sv */
// bench for the eeprom access controller: bus tasks, eeprom model, checks
// assumes the package, eac_top and the eeprom model are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_access_controller;
   import eac_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, prst, nak, pull, irq, sda;
   logic ee_scl, sda_oe, cfg_v, hresp_o, sda_o;
   logic [1:0] htrans, cfg_i;
   logic [6:0] a;
   logic [15:0] cfg_d;
   logic [31:0] haddr, hwdata, hrdata, rd_l, s, w;
   int n_errors, cmp_count, n_cfg, n;
   int exp_mem [int];
   assign sda = !(sda_oe | pull); // pull-up resolves the released wire
   eac_top eac_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp_o),
      .hrdata(hrdata), .fundamental_reset_in(prst), .ee_scl(ee_scl),
      .ee_sda_in(sda), .ee_sda_out(sda_o), .ee_sda_oe(sda_oe),
      .cfg_wr_valid(cfg_v), .cfg_wr_index(cfg_i), .cfg_wr_data(cfg_d),
      .irq(irq));
   eac_ee_model eac_ee_model_inst (.scl(ee_scl), .sda(sda), .nak(nak),
      .pull(pull));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   // hready is judged at the negedge so the sampling edge sees it settled
   task automatic rdy();
      @(negedge hclk);
      while (hready !== 1'b1)
         @(negedge hclk);
      rd_l = hrdata;
      @(posedge hclk);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, ad};
      hwrite <= wr;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
   endtask
   // one software cycle, then poll start until the engine drops it
   task automatic run(input logic c, input logic [15:0] d,
                      input logic [1:0] r);
      ahb(1'b1, OFF_CTRL, {d, a, 1'b0, r, 4'h8, c, 1'b1});
      n = 0;
      do
      begin
         ahb(1'b0, OFF_CTRL, 32'h0);
         n++;
      end
      while (rd_l[0] !== 1'b0 && n < 4000);
   endtask
   task automatic ck_irq(input logic e);
      @(negedge hclk);
      chk(32'(irq), 32'(e));
      @(posedge hclk);
   endtask
   task automatic pulse();
      prst <= 1'b1;
      @(posedge hclk);
      prst <= 1'b0;
      @(posedge hclk);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // autoload words must arrive in order with the stored values;
   // looked at mid-cycle so the registered pulse has settled
   always @(negedge hclk)
      if (cfg_v === 1'b1)
      begin
         chk(32'(cfg_d), 32'(exp_mem[cfg_i]));
         chk(32'(cfg_i), n_cfg);
         n_cfg++;
      end
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   initial
   begin
      repeat (40000) @(posedge hclk);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      {hresetn, hsel, hwrite, prst, nak, htrans, haddr, hwdata} = '0;
      s = 32'h79a0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, OFF_CTRL, 32'h0);
      chk(rd_l, 32'h60);
      // response is always okay and the data pin only ever pulls low
      chk(32'({hresp_o, sda_o}), 32'h0);
      ahb(1'b0, 8'hd8, 32'h0);
      chk(rd_l, 32'h0);
      $display("reset test done");
      // first write at the divided rate, the rest in test mode
      for (int i = 0; i < 5; i++)
      begin
         w = xs();
         a = (i < 4) ? 7'(i) : 7'h7f;
         exp_mem[a] = w[15:0];
         run(1'b1, w[15:0], i == 0 ? RATE_DIV : RATE_TEST);
         chk(32'(n > 1000), 32'(i == 0));
         chk(rd_l[9:0], {a[0], 1'b0, (i == 0) ? RATE_DIV : RATE_TEST,
             6'h22});
         run(1'b0, ~w[15:0], RATE_TEST);
         chk(rd_l, {w[15:0], a, 1'b0, RATE_TEST, 4'h8, 2'b00});
      end
      $display("cycle test done");
      ck_irq(1'b0);
      ahb(1'b0, OFF_IRQ_STS, 32'h0);
      chk(rd_l, 32'h1);
      ahb(1'b1, OFF_IRQ_MASK, 32'h7);
      ck_irq(1'b1);
      ahb(1'b1, OFF_IRQ_STS, 32'h7);
      ck_irq(1'b0);
      $display("irq test done");
      nak <= 1'b1;
      a = 7'h3;
      run(1'b0, 16'h0, RATE_TEST);
      chk(rd_l, {16'h0, a, 1'b0, RATE_TEST, 4'h9, 2'b00});
      ahb(1'b0, OFF_IRQ_STS, 32'h0);
      chk(rd_l & 32'h2, 32'h2);
      nak <= 1'b0;
      ahb(1'b1, OFF_IRQ_STS, 32'h7);
      $display("nack test done");
      // disabled load must stay silent, enabled load fetches four words
      pulse();
      repeat (300) @(posedge hclk);
      chk(n_cfg, 0);
      ahb(1'b1, OFF_CTRL, {24'h0, RATE_TEST, 6'h0});
      pulse();
      n = 0;
      do
      begin
         ahb(1'b0, OFF_IRQ_STS, 32'h0);
         n++;
      end
      while (rd_l[2] !== 1'b1 && n < 2000);
      chk(n_cfg, 4);
      ck_irq(1'b1);
      ahb(1'b0, OFF_CTRL, 32'h0);
      // the error flag of the nack test stays until a software start
      chk(rd_l & 32'h1c, 32'h1c);
      ahb(1'b0, OFF_CTRL, 32'h0);
      chk(rd_l & 32'h1c, 32'h14);
      $display("autoload test done");
      give_verdict();
   end
endmodule
`default_nettype wire
